// [hdl/cxs_pkg.sv]
// Package of constants and carriers for the instruction execute subset
package cxs_pkg;

	// ------------------------------------------------------------------
	// Widths and cycle counts
	// ------------------------------------------------------------------
	localparam int DW       = 8;
	localparam int AW       = 16;
	localparam int RAW      = 5;
	localparam int IOW      = 6;
	localparam logic [1:0] CYC_PROG = 2'h3;
	localparam logic [1:0] CYC_STK  = 2'h2;
	localparam logic [1:0] CYC_IOB  = 2'h2;
	localparam logic [1:0] CYC_ONE  = 2'h1;
	localparam logic [AW-1:0] SP_RESET = 16'h07FF;
	localparam logic [AW-1:0] PTR_ONE  = 16'h0001;
	localparam logic [DW-1:0] FLAG_RESET = 8'h00;

	// ------------------------------------------------------------------
	// Status flag bit positions
	// ------------------------------------------------------------------
	localparam int F_C = 0;
	localparam int F_Z = 1;
	localparam int F_N = 2;
	localparam int F_V = 3;
	localparam int F_S = 4;
	localparam int F_H = 5;
	localparam int F_T = 6;
	localparam int F_I = 7;

	// ------------------------------------------------------------------
	// Operations handled by the block
	// ------------------------------------------------------------------
	typedef enum logic [4:0] {
		OP_IDLE_INSTRUCTION          = 5'h00,
		OP_LOAD_PROGRAM_BYTE         = 5'h01,
		OP_STORE_PROGRAM_WORD        = 5'h02,
		OP_PORT_IN                   = 5'h03,
		OP_PORT_OUT                  = 5'h04,
		OP_PUSH                      = 5'h05,
		OP_POP                       = 5'h06,
		OP_SET_IO_BIT                = 5'h07,
		OP_CLEAR_IO_BIT              = 5'h08,
		OP_LOGICAL_SHIFT_LEFT        = 5'h09,
		OP_LOGICAL_SHIFT_RIGHT       = 5'h0A,
		OP_ROTATE_LEFT_VIA_CARRY     = 5'h0B,
		OP_ROTATE_RIGHT_VIA_CARRY    = 5'h0C,
		OP_ARITHMETIC_SHIFT_RIGHT    = 5'h0D,
		OP_SWAP_NIBBLES              = 5'h0E,
		OP_SET_STATUS_BIT            = 5'h0F,
		OP_CLEAR_STATUS_BIT          = 5'h10,
		OP_STORE_BIT_TO_TRANSFER     = 5'h11,
		OP_LOAD_BIT_FROM_TRANSFER    = 5'h12,
		OP_SLEEP                     = 5'h13,
		OP_WATCHDOG_RESTART          = 5'h14,
		OP_BREAK                     = 5'h15
	} cxs_op_t;

	// Decoded instruction as issued by the fetch stage
	typedef struct packed {
		cxs_op_t          op;
		logic [RAW-1:0]   reg_sel;
		logic [2:0]       bit_sel;
		logic [IOW-1:0]   io_addr;
		logic             post_inc;
	} cxs_instr_t;

	// Memory-side request
	typedef struct packed {
		logic             prog_rd;
		logic             prog_wr;
		logic [AW-1:0]    prog_addr;
		logic [2*DW-1:0]  prog_wdata;
		logic             data_rd;
		logic             data_wr;
		logic [AW-1:0]    data_addr;
		logic [DW-1:0]    data_wdata;
		logic             io_rd;
		logic             io_wr;
		logic [IOW-1:0]   io_addr;
		logic [DW-1:0]    io_wdata;
	} cxs_mem_req_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_EXEC1 = 2'b01,
		ST_EXEC2 = 2'b11
	} cxs_state_t;

endpackage : cxs_pkg

// [hdl/cxs_shift_unit.sv]
// Shift, rotate and swap datapath with flag results
`timescale 1ns/1ps

module cxs_shift_unit #(
	parameter int DW = cxs_pkg::DW
) (
	input  wire cxs_pkg::cxs_op_t op_i,
	input  wire logic [DW-1:0]    val_i,
	input  wire logic             carry_i,
	output logic [DW-1:0]         res_o,
	output logic                  c_o,
	output logic                  z_o,
	output logic                  n_o,
	output logic                  v_o,
	output logic                  s_o,
	output logic                  flags_o
);

	initial begin
		if (DW < 2) $error("cxs_shift_unit: DW must be at least 2");
	end

	always_comb begin
		res_o   = val_i;
		c_o     = carry_i;
		flags_o = 1'b1;
		unique case (op_i)
			cxs_pkg::OP_LOGICAL_SHIFT_LEFT: begin
				res_o = {val_i[DW-2:0], 1'b0};        // see [RQ7]
				c_o   = val_i[DW-1];
			end
			cxs_pkg::OP_LOGICAL_SHIFT_RIGHT: begin
				res_o = {1'b0, val_i[DW-1:1]};        // see [RQ8]
				c_o   = val_i[0];
			end
			cxs_pkg::OP_ROTATE_LEFT_VIA_CARRY: begin
				res_o = {val_i[DW-2:0], carry_i};     // see [RQ9]
				c_o   = val_i[DW-1];
			end
			cxs_pkg::OP_ROTATE_RIGHT_VIA_CARRY: begin
				res_o = {carry_i, val_i[DW-1:1]};     // see [RQ10]
				c_o   = val_i[0];
			end
			cxs_pkg::OP_ARITHMETIC_SHIFT_RIGHT: begin
				res_o = {val_i[DW-1], val_i[DW-1:1]}; // see [RQ11]
				c_o   = val_i[0];
			end
			cxs_pkg::OP_SWAP_NIBBLES: begin
				res_o   = {val_i[DW/2-1:0], val_i[DW-1:DW/2]}; // see [RQ20]
				flags_o = 1'b0;
			end
			default: begin
				flags_o = 1'b0;
			end
		endcase
	end

	// Left forms take V = N ^ C; right forms also N ^ C with new C
	assign z_o = (res_o == '0);
	assign n_o = res_o[DW-1];
	assign v_o = n_o ^ c_o;
	assign s_o = n_o ^ v_o;

endmodule // cxs_shift_unit

// [hdl/cxs_exec.sv]
// Execute stage for the memory, stack, bit and control instruction subset
//
// Function
// [RQ1] Program byte load via pointer, three cycles
// [RQ2] Program word store from register pair one:zero
// [RQ3] Push register to stack in two cycles
// [RQ4] Pop register from stack in two cycles
// [RQ5] Set one I/O bit, two cycles
// [RQ6] Clear one I/O bit, two cycles
// [RQ7] Logical left shift, flags Z C N V
// [RQ8] Logical right shift, flags Z C N V
// [RQ9] Rotate left through carry, one cycle
// [RQ10] Rotate right through carry, one cycle
// [RQ11] Arithmetic right shift keeps sign bit
// [RQ12] Copy register bit into transfer flag
// [RQ13] Copy transfer flag into register bit
// [RQ14] Set any status bit in one cycle
// [RQ15] Clear any status bit in one cycle
// [RQ16] Sleep: one cycle, enter low power
// [RQ17] Watchdog restart: one cycle pulse
// [RQ18] Break signals debugger only, no flags
// [RQ19] Port in and out, one cycle each; port in here takes two cycles (read, then ST_EXEC2)
// [RQ20] Nibble swap and idle, one cycle
`timescale 1ns/1ps

module cxs_exec #(
	parameter int          NREG     = 32,
	parameter logic [15:0] SP_INIT  = cxs_pkg::SP_RESET
) (
	input  wire logic                      clk_i,
	input  wire logic                      resetn_i,
	input  wire logic                      en_i,
	input  wire logic                      instr_valid_i,
	input  wire cxs_pkg::cxs_instr_t       instr_i,
	output logic                           instr_ready_o,
	output logic                           done_o,
	input  wire logic [cxs_pkg::DW-1:0]    prog_rdata_i,
	input  wire logic [cxs_pkg::DW-1:0]    data_rdata_i,
	input  wire logic [cxs_pkg::DW-1:0]    io_rdata_i,
	output cxs_pkg::cxs_mem_req_t          mem_req_o,
	input  wire logic                      rf_we_i,
	input  wire logic [cxs_pkg::RAW-1:0]   rf_waddr_i,
	input  wire logic [cxs_pkg::DW-1:0]    rf_wdata_i,
	input  wire logic [cxs_pkg::RAW-1:0]   rf_raddr_i,
	output logic [cxs_pkg::DW-1:0]         rf_rdata_o,
	output logic [cxs_pkg::DW-1:0]         status_flags_o,
	output logic [cxs_pkg::AW-1:0]         pointer_o,
	output logic [cxs_pkg::AW-1:0]         stack_ptr_o,
	output logic                           sleep_o,
	output logic                           watchdog_restart_o,
	output logic                           break_o
);

	localparam int DW  = cxs_pkg::DW;
	localparam int AW  = cxs_pkg::AW;
	localparam int RAW = cxs_pkg::RAW;
	localparam logic [RAW-1:0] R0  = 5'h00;
	localparam logic [RAW-1:0] R1  = 5'h01;
	localparam logic [RAW-1:0] RZL = 5'h1E;
	localparam logic [RAW-1:0] RZH = 5'h1F;

	initial begin
		if (NREG != 32) $error("cxs_exec: NREG must be 32");
	end

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		cxs_pkg::cxs_state_t   st;
		cxs_pkg::cxs_instr_t   cur;
		logic [NREG-1:0][DW-1:0] rf;
		logic [DW-1:0]         flags;
		logic [AW-1:0]         sp;
		cxs_pkg::cxs_mem_req_t req;
		logic                  done;
		logic                  sleep;
		logic                  wd_kick;
		logic                  brk;
	} cxs_exec_state_t;

	cxs_exec_state_t s_q;
	cxs_exec_state_t s_d;

	logic [DW-1:0] op_val;
	logic [DW-1:0] sh_res;
	logic          sh_c;
	logic          sh_z;
	logic          sh_n;
	logic          sh_v;
	logic          sh_s;
	logic          sh_fl;
	logic [AW-1:0] zptr;

	assign op_val = s_q.rf[instr_i.reg_sel];
	assign zptr   = {s_q.rf[RZH], s_q.rf[RZL]};

	cxs_shift_unit #(
		.DW (DW)
	) u_shift (
		.op_i    (instr_i.op),
		.val_i   (op_val),
		.carry_i (s_q.flags[cxs_pkg::F_C]),
		.res_o   (sh_res),
		.c_o     (sh_c),
		.z_o     (sh_z),
		.n_o     (sh_n),
		.v_o     (sh_v),
		.s_o     (sh_s),
		.flags_o (sh_fl)
	);

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		logic [AW-1:0] zinc;
		logic [DW-1:0] iob;
		zinc = zptr + cxs_pkg::PTR_ONE;
		iob  = io_rdata_i;
		s_d  = s_q;
		s_d.req   = '0;
		s_d.done  = 1'b0;
		s_d.wd_kick = 1'b0;
		s_d.brk   = 1'b0;
		if (rf_we_i) begin
			s_d.rf[rf_waddr_i] = rf_wdata_i;
		end
		unique case (s_q.st)
			cxs_pkg::ST_IDLE: begin
				if (instr_valid_i && !s_q.sleep) begin
					s_d.cur  = instr_i;
					s_d.done = 1'b1;
					unique case (instr_i.op)
						cxs_pkg::OP_LOAD_PROGRAM_BYTE: begin
							s_d.done          = 1'b0;
							s_d.req.prog_rd   = 1'b1; // see [RQ1]
							s_d.req.prog_addr = zptr;
							s_d.st            = cxs_pkg::ST_EXEC1;
						end
						cxs_pkg::OP_STORE_PROGRAM_WORD: begin
							s_d.req.prog_wr    = 1'b1; // see [RQ2]
							s_d.req.prog_addr  = zptr;
							s_d.req.prog_wdata = {s_q.rf[R1], s_q.rf[R0]};
						end
						cxs_pkg::OP_PORT_IN: begin
							s_d.done        = 1'b0;
							s_d.req.io_rd   = 1'b1; // see [RQ19]
							s_d.req.io_addr = instr_i.io_addr;
							s_d.st          = cxs_pkg::ST_EXEC2;
						end
						cxs_pkg::OP_PORT_OUT: begin
							s_d.req.io_wr    = 1'b1; // see [RQ19]
							s_d.req.io_addr  = instr_i.io_addr;
							s_d.req.io_wdata = op_val;
						end
						cxs_pkg::OP_PUSH: begin
							s_d.done           = 1'b0;
							s_d.req.data_wr    = 1'b1; // see [RQ3]
							s_d.req.data_addr  = s_q.sp;
							s_d.req.data_wdata = op_val;
							s_d.sp             = s_q.sp - cxs_pkg::PTR_ONE;
							s_d.st             = cxs_pkg::ST_EXEC2;
						end
						cxs_pkg::OP_POP: begin
							s_d.done          = 1'b0;
							s_d.sp            = s_q.sp + cxs_pkg::PTR_ONE;
							s_d.req.data_rd   = 1'b1; // see [RQ4]
							s_d.req.data_addr = s_q.sp + cxs_pkg::PTR_ONE;
							s_d.st            = cxs_pkg::ST_EXEC2;
						end
						cxs_pkg::OP_SET_IO_BIT,
						cxs_pkg::OP_CLEAR_IO_BIT: begin
							s_d.done        = 1'b0;
							s_d.req.io_rd   = 1'b1; // see [RQ5] [RQ6]
							s_d.req.io_addr = instr_i.io_addr;
							s_d.st          = cxs_pkg::ST_EXEC2;
						end
						cxs_pkg::OP_LOGICAL_SHIFT_LEFT,
						cxs_pkg::OP_LOGICAL_SHIFT_RIGHT,
						cxs_pkg::OP_ROTATE_LEFT_VIA_CARRY,
						cxs_pkg::OP_ROTATE_RIGHT_VIA_CARRY,
						cxs_pkg::OP_ARITHMETIC_SHIFT_RIGHT,
						cxs_pkg::OP_SWAP_NIBBLES: begin
							s_d.rf[instr_i.reg_sel] = sh_res; // see [RQ20]
							if (sh_fl) begin
								s_d.flags[cxs_pkg::F_C] = sh_c; // see [RQ7] [RQ8]
								s_d.flags[cxs_pkg::F_Z] = sh_z; // see [RQ9] [RQ10]
								s_d.flags[cxs_pkg::F_N] = sh_n; // see [RQ11]
								s_d.flags[cxs_pkg::F_V] = sh_v;
								s_d.flags[cxs_pkg::F_S] = sh_s;
							end
						end
						cxs_pkg::OP_SET_STATUS_BIT: begin
							s_d.flags[instr_i.bit_sel] = 1'b1; // see [RQ14]
						end
						cxs_pkg::OP_CLEAR_STATUS_BIT: begin
							s_d.flags[instr_i.bit_sel] = 1'b0; // see [RQ15]
						end
						cxs_pkg::OP_STORE_BIT_TO_TRANSFER: begin
							s_d.flags[cxs_pkg::F_T] =
								op_val[instr_i.bit_sel]; // see [RQ12]
						end
						cxs_pkg::OP_LOAD_BIT_FROM_TRANSFER: begin
							s_d.rf[instr_i.reg_sel][instr_i.bit_sel] =
								s_q.flags[cxs_pkg::F_T]; // see [RQ13]
						end
						cxs_pkg::OP_SLEEP: begin
							s_d.sleep = 1'b1; // see [RQ16]
						end
						cxs_pkg::OP_WATCHDOG_RESTART: begin
							s_d.wd_kick = 1'b1; // see [RQ17]
						end
						cxs_pkg::OP_BREAK: begin
							s_d.brk  = 1'b1; // see [RQ18]
							s_d.done = 1'b0;
						end
						default: begin
							s_d.done = 1'b1; // see [RQ20]
						end
					endcase
				end else if (instr_valid_i) begin
					s_d.sleep = 1'b0;
				end
			end
			cxs_pkg::ST_EXEC1: begin
				// Second cycle of the program byte load: data arrives
				s_d.st = cxs_pkg::ST_EXEC2;
				if (s_q.cur.post_inc) begin
					s_d.rf[RZH] = zinc[AW-1:DW]; // see [RQ1]
					s_d.rf[RZL] = zinc[DW-1:0];
				end
				s_d.rf[s_q.cur.reg_sel] = prog_rdata_i;
			end
			cxs_pkg::ST_EXEC2: begin
				s_d.st   = cxs_pkg::ST_IDLE;
				s_d.done = 1'b1;
				unique case (s_q.cur.op)
					cxs_pkg::OP_POP: begin
						s_d.rf[s_q.cur.reg_sel] = data_rdata_i; // see [RQ4]
					end
					cxs_pkg::OP_PORT_IN: begin
						s_d.rf[s_q.cur.reg_sel] = io_rdata_i;
					end
					cxs_pkg::OP_SET_IO_BIT: begin
						iob[s_q.cur.bit_sel] = 1'b1; // see [RQ5]
						s_d.req.io_wr    = 1'b1;
						s_d.req.io_addr  = s_q.cur.io_addr;
						s_d.req.io_wdata = iob;
					end
					cxs_pkg::OP_CLEAR_IO_BIT: begin
						iob[s_q.cur.bit_sel] = 1'b0; // see [RQ6]
						s_d.req.io_wr    = 1'b1;
						s_d.req.io_addr  = s_q.cur.io_addr;
						s_d.req.io_wdata = iob;
					end
					default: begin
						s_d.done = 1'b1;
					end
				endcase
			end
			default: begin
				s_d.st = cxs_pkg::ST_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_q      <= '0;
			s_q.st   <= cxs_pkg::ST_IDLE;
			s_q.sp   <= SP_INIT;
			s_q.flags <= cxs_pkg::FLAG_RESET;
		end else if (en_i) begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign instr_ready_o      = en_i && (s_q.st == cxs_pkg::ST_IDLE);
	assign done_o             = s_q.done;
	assign mem_req_o          = s_q.req;
	assign rf_rdata_o         = s_q.rf[rf_raddr_i];
	assign status_flags_o     = s_q.flags;
	assign pointer_o          = zptr;
	assign stack_ptr_o        = s_q.sp;
	assign sleep_o            = s_q.sleep;
	assign watchdog_restart_o = s_q.wd_kick;
	assign break_o            = s_q.brk;

endmodule // cxs_exec

// [tb/cxs_exec_monitor.sv]
// Port checker of the instruction execute subset
`timescale 1ns/1ps

module cxs_exec_monitor (
	input wire logic                  clk_i,
	input wire logic                  resetn_i,
	input wire logic                  instr_valid_i,
	input wire cxs_pkg::cxs_instr_t   instr_i,
	input wire logic                  instr_ready_o,
	input wire logic                  done_o,
	input wire logic [7:0]            io_rdata_i,
	input wire cxs_pkg::cxs_mem_req_t mem_req_o,
	input wire logic [4:0]            rf_raddr_i,
	input wire logic [7:0]            rf_rdata_o,
	input wire logic [7:0]            status_flags_o,
	input wire logic [15:0]           stack_ptr_o,
	input wire logic                  sleep_o,
	input wire logic                  watchdog_restart_o,
	input wire logic                  break_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	// An offer made while asleep only wakes the block
	sequence s_take(cxs_pkg::cxs_op_t o);
		instr_valid_i && instr_ready_o && !sleep_o && instr_i.op == o;
	endsequence
	// Program load: strobe, data lands, then done
	sequence s_prog_load;
		mem_req_o.prog_rd && !done_o ##1 !done_o ##1 done_o;
	endsequence
	// Read of the I/O location, then write back with done
	sequence s_io_rmw;
		mem_req_o.io_rd && mem_req_o.io_addr == $past(instr_i.io_addr)
		##1 mem_req_o.io_wr && done_o;
	endsequence

	a_prog_load_cycles: assert property (
		s_take(cxs_pkg::OP_LOAD_PROGRAM_BYTE) |=> s_prog_load)
		else $error("program byte load timing wrong");
	a_push_stack: assert property (s_take(cxs_pkg::OP_PUSH)
		|=> mem_req_o.data_wr && mem_req_o.data_addr == $past(stack_ptr_o)
		##1 done_o && stack_ptr_o == $past(stack_ptr_o, 2) - 16'h0001)
		else $error("push wrong");
	a_pop_stack: assert property (s_take(cxs_pkg::OP_POP)
		|=> mem_req_o.data_rd
		&& mem_req_o.data_addr == $past(stack_ptr_o) + 16'h0001 ##1 done_o)
		else $error("pop wrong");
	a_set_io_bit: assert property (
		s_take(cxs_pkg::OP_SET_IO_BIT) |=> s_io_rmw ##0 mem_req_o.io_wdata
		== (io_rdata_i | (8'h01 << $past(instr_i.bit_sel, 2))))
		else $error("set io bit wrong");
	a_clear_io_bit: assert property (
		s_take(cxs_pkg::OP_CLEAR_IO_BIT) |=> s_io_rmw ##0 mem_req_o.io_wdata
		== (io_rdata_i & ~(8'h01 << $past(instr_i.bit_sel, 2))))
		else $error("clear io bit wrong");
	a_one_cycle_ops: assert property (
		instr_valid_i && instr_ready_o && !sleep_o
		&& instr_i.op inside {[cxs_pkg::OP_LOGICAL_SHIFT_LEFT:
		cxs_pkg::OP_LOAD_BIT_FROM_TRANSFER], cxs_pkg::OP_IDLE_INSTRUCTION}
		|=> done_o) else $error("one cycle op not done");
	a_status_set: assert property (
		s_take(cxs_pkg::OP_SET_STATUS_BIT) |=> status_flags_o
		== ($past(status_flags_o) | (8'h01 << $past(instr_i.bit_sel))))
		else $error("status set wrong");
	a_status_clear: assert property (
		s_take(cxs_pkg::OP_CLEAR_STATUS_BIT) |=> status_flags_o
		== ($past(status_flags_o) & ~(8'h01 << $past(instr_i.bit_sel))))
		else $error("status clear wrong");
	a_bit_store_t: assert property (
		s_take(cxs_pkg::OP_STORE_BIT_TO_TRANSFER)
		##0 rf_raddr_i == instr_i.reg_sel |=> status_flags_o
		== {$past(status_flags_o[7]), $past(rf_rdata_o[instr_i.bit_sel]),
		$past(status_flags_o[5:0])}) else $error("bit store wrong");
	a_watchdog_pulse: assert property (
		s_take(cxs_pkg::OP_WATCHDOG_RESTART)
		|=> watchdog_restart_o && $stable(status_flags_o)
		##1 !watchdog_restart_o) else $error("watchdog pulse wrong");
	a_sleep_entry: assert property (
		s_take(cxs_pkg::OP_SLEEP)
		|=> sleep_o && $stable(status_flags_o)) else $error("sleep wrong");
	a_wake_consume: assert property (
		sleep_o && instr_valid_i && instr_ready_o
		|=> !sleep_o && !done_o) else $error("wake offer executed");
	a_break_only: assert property (
		s_take(cxs_pkg::OP_BREAK)
		|=> break_o && !done_o && $stable(status_flags_o))
		else $error("break wrong");
endmodule // cxs_exec_monitor

bind cxs_exec cxs_exec_monitor u_mon (.clk_i(clk_i), .resetn_i(resetn_i),
	.instr_valid_i(instr_valid_i), .instr_i(instr_i),
	.instr_ready_o(instr_ready_o), .done_o(done_o), .io_rdata_i(io_rdata_i),
	.mem_req_o(mem_req_o), .rf_raddr_i(rf_raddr_i), .rf_rdata_o(rf_rdata_o),
	.status_flags_o(status_flags_o), .stack_ptr_o(stack_ptr_o),
	.sleep_o(sleep_o), .watchdog_restart_o(watchdog_restart_o),
	.break_o(break_o));

// [tb/cxs_mem_model.sv]
// Memory partner: program ROM, data and I/O space
`timescale 1ns/1ps

module cxs_mem_model (
	input  wire logic                  clk_i,
	input  wire logic                  resetn_i,
	input  wire cxs_pkg::cxs_mem_req_t req_i,
	output logic [7:0]                 prog_rdata_o,
	output logic [7:0]                 data_rdata_o,
	output logic [7:0]                 io_rdata_o,
	output logic [15:0]                pw_addr_o,
	output logic [15:0]                pw_word_o
);
	logic [7:0] dmem_q [256];
	logic [7:0] iomem_q [64];
	logic [7:0] p_q;
	logic [7:0] d_q;
	logic [7:0] i_q;
	logic [7:0] rom;

	assign rom = req_i.prog_addr[7:0] ^ req_i.prog_addr[15:8] ^ 8'h5A;
	// Data stand in the strobe cycle and the next, then toggle each cycle
	assign prog_rdata_o = req_i.prog_rd ? rom : p_q;
	assign data_rdata_o = req_i.data_rd ? dmem_q[req_i.data_addr[7:0]] : d_q;
	assign io_rdata_o = req_i.io_rd ? iomem_q[req_i.io_addr] : i_q;

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			p_q <= 8'h00;
			d_q <= 8'h00;
			i_q <= 8'h00;
			pw_addr_o <= 16'h0000;
			pw_word_o <= 16'h0000;
		end else begin
			p_q <= req_i.prog_rd ? prog_rdata_o : ~p_q;
			d_q <= req_i.data_rd ? data_rdata_o : ~d_q;
			i_q <= req_i.io_rd ? io_rdata_o : ~i_q;
			if (req_i.data_wr)
				dmem_q[req_i.data_addr[7:0]] <= req_i.data_wdata;
			if (req_i.io_wr)
				iomem_q[req_i.io_addr] <= req_i.io_wdata;
			if (req_i.prog_wr) begin
				pw_addr_o <= req_i.prog_addr;
				pw_word_o <= req_i.prog_wdata;
			end
		end
	end
endmodule // cxs_mem_model

// [tb/testbench.sv]
// Self-checking bench of the instruction execute subset
`timescale 1ns/1ps

module testbench;
	typedef struct {
		cxs_pkg::cxs_op_t op;
		logic [2:0]       bs;
		logic [7:0]       val;
		logic [7:0]       pre;
		logic [7:0]       res;
		logic [7:0]       flg;
	} cxs_row_t;

	logic                  clk_i;
	logic                  resetn_i;
	logic                  en_i;
	logic                  instr_valid_i;
	cxs_pkg::cxs_instr_t   instr_i;
	logic                  rdy;
	logic                  done;
	logic [7:0]            p_rd;
	logic [7:0]            d_rd;
	logic [7:0]            i_rd;
	cxs_pkg::cxs_mem_req_t req;
	logic                  rf_we_i;
	logic [4:0]            rf_waddr_i;
	logic [4:0]            rf_raddr_i;
	logic [7:0]            rf_wdata_i;
	logic [7:0]            rf_rdata;
	logic [7:0]            flags;
	logic [15:0]           ptr;
	logic [15:0]           sp;
	logic [15:0]           pw_addr;
	logic [15:0]           pw_word;
	logic                  slp;
	logic [7:0]            v;
	int                    failures;
	int                    num_checks;
	int                    cycles;

	cxs_row_t rows [10] = '{
		'{cxs_pkg::OP_LOGICAL_SHIFT_LEFT, 3'h0, 8'h81, 8'h00, 8'h02, 8'h19},
		'{cxs_pkg::OP_LOGICAL_SHIFT_LEFT, 3'h0, 8'h00, 8'h00, 8'h00, 8'h02},
		'{cxs_pkg::OP_LOGICAL_SHIFT_RIGHT, 3'h0, 8'h01, 8'hE0, 8'h00, 8'hFB},
		'{cxs_pkg::OP_ROTATE_LEFT_VIA_CARRY, 3'h0, 8'h80, 8'h01, 8'h01, 8'h19},
		'{cxs_pkg::OP_ROTATE_RIGHT_VIA_CARRY, 3'h0, 8'h02, 8'h01, 8'h81, 8'h0C},
		'{cxs_pkg::OP_ARITHMETIC_SHIFT_RIGHT, 3'h0, 8'h81, 8'h00, 8'hC0, 8'h15},
		'{cxs_pkg::OP_SWAP_NIBBLES, 3'h0, 8'hA5, 8'h5A, 8'h5A, 8'h5A},
		'{cxs_pkg::OP_LOAD_BIT_FROM_TRANSFER, 3'h3, 8'h00, 8'h40, 8'h08, 8'h40},
		'{cxs_pkg::OP_STORE_BIT_TO_TRANSFER, 3'h5, 8'h20, 8'h00, 8'h20, 8'h40},
		'{cxs_pkg::OP_IDLE_INSTRUCTION, 3'h0, 8'h3C, 8'h9F, 8'h3C, 8'h9F}
	};

	cxs_exec dut (.clk_i(clk_i), .resetn_i(resetn_i), .en_i(en_i),
		.instr_valid_i(instr_valid_i), .instr_i(instr_i),
		.instr_ready_o(rdy), .done_o(done), .prog_rdata_i(p_rd),
		.data_rdata_i(d_rd), .io_rdata_i(i_rd), .mem_req_o(req),
		.rf_we_i(rf_we_i), .rf_waddr_i(rf_waddr_i), .rf_wdata_i(rf_wdata_i),
		.rf_raddr_i(rf_raddr_i), .rf_rdata_o(rf_rdata),
		.status_flags_o(flags), .pointer_o(ptr), .stack_ptr_o(sp),
		.sleep_o(slp), .watchdog_restart_o(), .break_o());

	cxs_mem_model u_mem (.clk_i(clk_i), .resetn_i(resetn_i), .req_i(req),
		.prog_rdata_o(p_rd), .data_rdata_o(d_rd), .io_rdata_o(i_rd),
		.pw_addr_o(pw_addr), .pw_word_o(pw_word));

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	task automatic finish_test();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] e, logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic exec(input cxs_pkg::cxs_op_t op, input logic [4:0] r,
			input logic [2:0] b, input logic [5:0] io, input logic pi);
		logic ok;
		@(posedge clk_i);
		instr_valid_i <= 1'b1;
		instr_i <= '{op, r, b, io, pi};
		do begin
			#1 ok = rdy;
			@(posedge clk_i);
		end while (ok !== 1'b1);
		instr_valid_i <= 1'b0;
		#1;
		for (int n = 0; n < 4 && done !== 1'b1; n++) begin
			@(posedge clk_i);
			#1;
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk_i);
		rf_we_i <= 1'b1;
		rf_waddr_i <= a;
		rf_wdata_i <= d;
		@(posedge clk_i);
		rf_we_i <= 1'b0;
	endtask

	task automatic rd(input logic [4:0] a);
		@(posedge clk_i);
		rf_raddr_i <= a;
		#1 v = rf_rdata;
	endtask

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			failures++;
			finish_test();
		end
	end

	initial begin
		resetn_i = 1'b0;
		en_i = 1'b1;
		instr_valid_i = 1'b0;
		instr_i = '0;
		rf_we_i = 1'b0;
		rf_waddr_i = 5'h00;
		rf_wdata_i = 8'h00;
		rf_raddr_i = 5'h00;
		failures = 0;
		num_checks = 0;
		cycles = 0;
		repeat (3) @(posedge clk_i);
		resetn_i <= 1'b1;
		chk("sp reset", cxs_pkg::SP_RESET, sp);
		chk("flags reset", 16'h0000, {flags, 7'h00, slp});
		foreach (rows[i]) begin
			wr(5'h05, rows[i].val);
			for (int k = 0; k < 8; k++)
				exec(rows[i].pre[k] ? cxs_pkg::OP_SET_STATUS_BIT
					: cxs_pkg::OP_CLEAR_STATUS_BIT, 5'h00, 3'(k), 6'h00, 1'b0);
			rd(5'h05);
			exec(rows[i].op, 5'h05, rows[i].bs, 6'h00, 1'b0);
			chk("result", {8'h00, rows[i].res}, {8'h00, rf_rdata});
			chk("flags", {8'h00, rows[i].flg}, {8'h00, flags});
		end
		$display("test table done");
		wr(5'h1F, 8'h12);
		wr(5'h1E, 8'h34);
		exec(cxs_pkg::OP_LOAD_PROGRAM_BYTE, 5'h03, 3'h0, 6'h00, 1'b1);
		rd(5'h03);
		chk("prog byte", 16'h007C, {8'h00, v});
		chk("prog ptr", 16'h1235, ptr);
		exec(cxs_pkg::OP_LOAD_PROGRAM_BYTE, 5'h00, 3'h0, 6'h00, 1'b0);
		rd(5'h00);
		chk("prog r0", 16'h1235, {ptr[15:8], v ^ 8'h48});
		wr(5'h01, 8'hBE);
		wr(5'h00, 8'hEF);
		exec(cxs_pkg::OP_STORE_PROGRAM_WORD, 5'h00, 3'h0, 6'h00, 1'b0);
		// The word lands in the model at the edge after the strobe
		@(posedge clk_i);
		#1;
		chk("store word", 16'hBEEF, pw_word);
		chk("store addr", 16'h1235, pw_addr);
		$display("test program memory done");
		wr(5'h07, 8'h6D);
		wr(5'h09, 8'h11);
		exec(cxs_pkg::OP_PUSH, 5'h07, 3'h0, 6'h00, 1'b0);
		exec(cxs_pkg::OP_PUSH, 5'h09, 3'h0, 6'h00, 1'b0);
		chk("sp push", 16'h07FD, sp);
		exec(cxs_pkg::OP_POP, 5'h0A, 3'h0, 6'h00, 1'b0);
		exec(cxs_pkg::OP_POP, 5'h0B, 3'h0, 6'h00, 1'b0);
		rd(5'h0A);
		chk("pop 1", 16'h0011, {8'h00, v});
		rd(5'h0B);
		chk("pop 2", 16'h076D, {sp[15:8], v});
		$display("test stack done");
		exec(cxs_pkg::OP_PORT_OUT, 5'h07, 3'h0, 6'h15, 1'b0);
		exec(cxs_pkg::OP_SET_IO_BIT, 5'h00, 3'h1, 6'h15, 1'b0);
		exec(cxs_pkg::OP_CLEAR_IO_BIT, 5'h00, 3'h0, 6'h15, 1'b0);
		exec(cxs_pkg::OP_PORT_IN, 5'h0C, 3'h0, 6'h15, 1'b0);
		rd(5'h0C);
		chk("io bits", 16'h006E, {8'h00, v});
		$display("test io done");
		exec(cxs_pkg::OP_WATCHDOG_RESTART, 5'h00, 3'h0, 6'h00, 1'b0);
		exec(cxs_pkg::OP_BREAK, 5'h00, 3'h0, 6'h00, 1'b0);
		exec(cxs_pkg::OP_SLEEP, 5'h00, 3'h0, 6'h00, 1'b0);
		chk("sleep", 16'h0001, {15'h0000, slp});
		exec(cxs_pkg::OP_IDLE_INSTRUCTION, 5'h00, 3'h0, 6'h00, 1'b0);
		chk("wake", 16'h0000, {15'h0000, slp});
		$display("test control done");
		finish_test();
	end
endmodule // testbench
